/* File: hw/fiber_ctrl_status_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module fiber_ctrl_status_regs (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // Management pins
   input wire logic mdc_in,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_out,
   // Straps
   input wire logic [4:0] phy_addr_in,
   input wire logic negotiation_enable_strap_in,
   // Fiber logic state, same clock
   input wire logic [1:0] media_mode_in,
   input wire logic [1:0] line_speed_in,
   input wire fiber_regs_pkg::fiber_live_t live_in,
   // Controls to the fiber logic
   output logic sw_reset_out,
   output logic aneg_restart_out,
   output logic aneg_enable_out,
   output logic power_down_out,
   output logic duplex_out,
   output logic [1:0] speed_out
);

   logic [7:0] sync_w;
   logic mdc_s, mdio_s, strap_s;
   logic [4:0] addr_s;
   logic mdc_prev_q, rise;
   fiber_regs_pkg::mgmt_state_t state_q;
   logic [3:0] cnt_q;
   logic [10:0] hdr_q;
   logic [11:0] hdr_full;
   logic is_rd_q, is_wr_q;
   logic [4:0] reg_q;
   logic [15:0] sh_q;
   logic hdr_done, addr_hit, stat_rd, ctrl_wr;
   logic [15:0] wdata, rd_data;
   logic [1:0] init_cnt_q;
   logic init_load, aneg_en_q, pd_q, duplex_wr_q;
   logic [1:0] speed_wr_q, speed_rd;
   logic en_chg, pd_exit, swrst_req, restart_req, apply;
   logic sgmii, link_lat_q, rf_lat_q, rf_live;

   // Pins into the clock domain
   pin_sync #(.WIDTH(8)) u_sync (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .d_in({negotiation_enable_strap_in, phy_addr_in, mdio_in, mdc_in}),
      .q_out(sync_w)
   );

   assign mdc_s = sync_w[0];
   assign mdio_s = sync_w[1];
   assign addr_s = sync_w[6:2];
   assign strap_s = sync_w[7];

   // Management clock edge finder
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mdc_prev_q <= 1'b0;
      end else begin
         mdc_prev_q <= mdc_s;
      end
   end

   assign rise = mdc_s & ~mdc_prev_q;

   // Header decode
   assign hdr_full = {hdr_q, mdio_s};
   assign hdr_done = (state_q == fiber_regs_pkg::ST_HDR) && rise &&
                     (cnt_q == fiber_regs_pkg::HDR_LAST);
   assign addr_hit = hdr_full[9:5] == addr_s;
   assign stat_rd = hdr_done && addr_hit &&
                    (hdr_full[11:10] == fiber_regs_pkg::OP_READ) &&
                    (hdr_full[4:0] == fiber_regs_pkg::REG_STATUS);
   assign ctrl_wr = (state_q == fiber_regs_pkg::ST_DATA) && rise &&
                    (cnt_q == fiber_regs_pkg::DATA_LAST) && is_wr_q &&
                    (reg_q == fiber_regs_pkg::REG_CONTROL);
   assign wdata = {sh_q[14:0], mdio_s};

   // Frame engine; a lone zero on an idle line opens a frame
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= fiber_regs_pkg::ST_IDLE;
         cnt_q <= 4'h0;
         hdr_q <= 11'h000;
      end else if (rise) begin
         case (state_q)
            fiber_regs_pkg::ST_IDLE: begin
               if (!mdio_s) begin
                  state_q <= fiber_regs_pkg::ST_START;
               end
            end
            fiber_regs_pkg::ST_START: begin
               cnt_q <= 4'h0;
               state_q <= mdio_s ? fiber_regs_pkg::ST_HDR
                                 : fiber_regs_pkg::ST_IDLE;
            end
            fiber_regs_pkg::ST_HDR: begin
               hdr_q <= hdr_full[10:0];
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == fiber_regs_pkg::HDR_LAST) begin
                  state_q <= fiber_regs_pkg::ST_TA;
                  cnt_q <= 4'h0;
               end
            end
            fiber_regs_pkg::ST_TA: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == fiber_regs_pkg::TA_LAST) begin
                  state_q <= fiber_regs_pkg::ST_DATA;
                  cnt_q <= 4'h0;
               end
            end
            fiber_regs_pkg::ST_DATA: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == fiber_regs_pkg::DATA_LAST) begin
                  state_q <= fiber_regs_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= fiber_regs_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Frame kind and target, caught at end of header
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         is_rd_q <= 1'b0;
         is_wr_q <= 1'b0;
         reg_q <= 5'h00;
      end else if (hdr_done) begin
         is_rd_q <= addr_hit &&
                    (hdr_full[11:10] == fiber_regs_pkg::OP_READ);
         is_wr_q <= addr_hit &&
                    (hdr_full[11:10] == fiber_regs_pkg::OP_WRITE);
         reg_q <= hdr_full[4:0];
      end
   end

   // Data shifter: loads read data, shifts write data in
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sh_q <= 16'h0000;
      end else if (hdr_done) begin
         sh_q <= rd_data;
      end else if (rise && state_q == fiber_regs_pkg::ST_DATA) begin
         sh_q <= wdata;
      end
   end

   // Pin drive: zero in second turnaround bit, then data MSB first
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mdio_oe_out <= 1'b0;
         mdio_out <= 1'b0;
      end else if (rise) begin
         if (state_q == fiber_regs_pkg::ST_TA && is_rd_q) begin
            mdio_oe_out <= 1'b1;
            mdio_out <= (cnt_q == fiber_regs_pkg::TA_LAST) ? sh_q[15]
                                                           : 1'b0;
         end else if (state_q == fiber_regs_pkg::ST_DATA && is_rd_q &&
                      cnt_q != fiber_regs_pkg::DATA_LAST) begin
            mdio_out <= sh_q[14];
         end else begin
            mdio_oe_out <= 1'b0;
            mdio_out <= 1'b0;
         end
      end
   end

   // Strap capture after release
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         init_cnt_q <= 2'h0;
      end else if (init_cnt_q != fiber_regs_pkg::INIT_DONE) begin
         init_cnt_q <= init_cnt_q + 2'h1;
      end
   end

   assign init_load = init_cnt_q == fiber_regs_pkg::INIT_LOAD;

   // Events that reset or restart the fiber logic
   assign en_chg = ctrl_wr &&
                   (wdata[fiber_regs_pkg::CTL_ANEG_EN] != aneg_en_q);
   assign pd_exit = ctrl_wr && pd_q &&
                    !wdata[fiber_regs_pkg::CTL_POWER_DOWN];
   assign swrst_req = (ctrl_wr && wdata[fiber_regs_pkg::CTL_SW_RESET]) ||
                      pd_exit;
   assign restart_req = (ctrl_wr && wdata[fiber_regs_pkg::CTL_RESTART]) ||
                        en_chg || swrst_req || init_load;
   assign apply = restart_req;

   // Negotiation enable: strap at hardware reset, kept by soft reset
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         aneg_en_q <= 1'b0;
      end else if (init_load) begin
         aneg_en_q <= strap_s;
      end else if (ctrl_wr) begin
         aneg_en_q <= wdata[fiber_regs_pkg::CTL_ANEG_EN];
      end
   end

   // Power down; a soft reset returns it to normal
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pd_q <= 1'b0;
      end else if (ctrl_wr) begin
         pd_q <= wdata[fiber_regs_pkg::CTL_POWER_DOWN] &&
                 !wdata[fiber_regs_pkg::CTL_SW_RESET];
      end
   end

   // Written duplex and speed, held across soft reset
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         duplex_wr_q <= fiber_regs_pkg::RST_DUPLEX;
         speed_wr_q <= fiber_regs_pkg::RST_SPEED;
      end else if (ctrl_wr) begin
         duplex_wr_q <= wdata[fiber_regs_pkg::CTL_DUPLEX];
         if (media_mode_in == fiber_regs_pkg::MODE_SGMII_SW) begin
            speed_wr_q <= {wdata[fiber_regs_pkg::CTL_SPEED_MSB],
                           wdata[fiber_regs_pkg::CTL_SPEED_LSB]};
         end
      end
   end

   // Speed bits as the media mode dictates
   always_comb begin
      case (media_mode_in)
         fiber_regs_pkg::MODE_100FX: speed_rd = fiber_regs_pkg::SPEED_100;
         fiber_regs_pkg::MODE_1000X: speed_rd = fiber_regs_pkg::SPEED_1000;
         fiber_regs_pkg::MODE_SGMII_AUTO: begin
            speed_rd = {line_speed_in == fiber_regs_pkg::SPEED_1000,
                        line_speed_in == fiber_regs_pkg::SPEED_100};
         end
         default: speed_rd = speed_wr_q;
      endcase
   end

   // Pulses and applied controls to the fiber logic
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sw_reset_out <= 1'b0;
         aneg_restart_out <= 1'b0;
      end else begin
         sw_reset_out <= swrst_req;
         aneg_restart_out <= restart_req;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         duplex_out <= fiber_regs_pkg::RST_DUPLEX;
      end else if (apply) begin
         duplex_out <= ctrl_wr ? wdata[fiber_regs_pkg::CTL_DUPLEX]
                               : duplex_wr_q;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         aneg_enable_out <= 1'b0;
         power_down_out <= 1'b0;
         speed_out <= fiber_regs_pkg::RST_SPEED;
      end else begin
         aneg_enable_out <= aneg_en_q &&
                            (media_mode_in != fiber_regs_pkg::MODE_100FX);
         power_down_out <= pd_q;
         speed_out <= speed_rd;
      end
   end

   // Latched link and remote fault; the read reloads live values
   assign sgmii = media_mode_in[1];
   assign rf_live = live_in.remote_fault && !sgmii;
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         link_lat_q <= 1'b0;
         rf_lat_q <= 1'b0;
      end else if (sw_reset_out) begin
         link_lat_q <= 1'b0;
         rf_lat_q <= rf_live;
      end else if (stat_rd) begin
         link_lat_q <= live_in.link_up;
         rf_lat_q <= rf_live;
      end else begin
         link_lat_q <= link_lat_q && live_in.link_up;
         rf_lat_q <= (rf_lat_q && !sgmii) || rf_live;
      end
   end

   // Read data for the addressed register
   always_comb begin
      rd_data = 16'h0000;
      if (hdr_full[4:0] == fiber_regs_pkg::REG_CONTROL) begin
         rd_data[fiber_regs_pkg::CTL_SW_RESET] = sw_reset_out;
         rd_data[fiber_regs_pkg::CTL_LOOPBACK] = 1'b0;
         rd_data[fiber_regs_pkg::CTL_SPEED_LSB] = speed_rd[0];
         rd_data[fiber_regs_pkg::CTL_ANEG_EN] = aneg_en_q;
         rd_data[fiber_regs_pkg::CTL_POWER_DOWN] = pd_q;
         rd_data[fiber_regs_pkg::CTL_ISOLATE] = 1'b0;
         rd_data[fiber_regs_pkg::CTL_RESTART] = aneg_restart_out;
         rd_data[fiber_regs_pkg::CTL_DUPLEX] = duplex_wr_q;
         rd_data[fiber_regs_pkg::CTL_COL_TEST] = 1'b0;
         rd_data[fiber_regs_pkg::CTL_SPEED_MSB] = speed_rd[1];
      end else if (hdr_full[4:0] == fiber_regs_pkg::REG_STATUS) begin
         rd_data[fiber_regs_pkg::STA_T4] = 1'b0;
         rd_data[fiber_regs_pkg::STA_X_FD] =
            media_mode_in == fiber_regs_pkg::MODE_100FX;
         rd_data[fiber_regs_pkg::STA_X_HD] =
            media_mode_in == fiber_regs_pkg::MODE_100FX;
         rd_data[fiber_regs_pkg::STA_10_FD] = 1'b0;
         rd_data[fiber_regs_pkg::STA_10_HD] = 1'b0;
         rd_data[fiber_regs_pkg::STA_T2_FD] = 1'b0;
         rd_data[fiber_regs_pkg::STA_T2_HD] = 1'b0;
         rd_data[fiber_regs_pkg::STA_EXT_STATUS] = 1'b1;
         rd_data[fiber_regs_pkg::STA_PREAMBLE_SUP] = 1'b1;
         rd_data[fiber_regs_pkg::STA_ANEG_DONE] = live_in.aneg_done &&
            !live_in.aneg_bypass && aneg_enable_out;
         rd_data[fiber_regs_pkg::STA_REMOTE_FAULT] =
            rf_lat_q && !sgmii;
         rd_data[fiber_regs_pkg::STA_ANEG_ABILITY] =
            media_mode_in != fiber_regs_pkg::MODE_100FX;
         rd_data[fiber_regs_pkg::STA_LINK] = link_lat_q;
         rd_data[fiber_regs_pkg::STA_EXT_CAP] = 1'b1;
      end
   end

endmodule

`default_nettype wire

/* File: hw/fiber_regs_pkg.sv */
// Notes on behaviour
// - Changing negotiation enable drops link, restarts negotiation, sets restart bit.
// - In 100BASE-FX mode negotiation enable has no effect on the link; a change still pulses restart and applies duplex.
// - Hardware reset loads negotiation enable from strap; software reset keeps it.
// - Leaving power down performs software reset and negotiation restart.
// - Isolate bit is read-only and reads zero.
// - Restart bit self-clears; negotiation restarts after resets or enable change.
// - Written duplex applies only on reset, restart, enable change, power-up.
// - Collision test bit reads zero; writes do nothing.
// - Speed MSB follows media mode: 0, 1, gigabit-only, or writable.
// - 100BASE-X duplex ability bits read 1 only in mode 00.
// - T4, T2 and 10 Mbps ability bits always read zero.
// - Extended-status bit always reads 1.
// - Preamble suppression reads 1; frames without preamble are accepted.
// - Negotiation-complete set only on true completion, not bypass or disabled.
// - Remote fault latches high; always reads 0 in SGMII modes.
// - Negotiation ability reads 0 in mode 00, else 1.
// - Link status latches low until read; second read shows live state.
// - Software reset bit resets fiber logic at once and self-clears.
package fiber_regs_pkg;

   // Register addresses on the management bus
   localparam logic [4:0] REG_CONTROL = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h01;

   // Control register fields
   localparam int CTL_SW_RESET = 15;
   localparam int CTL_LOOPBACK = 14;
   localparam int CTL_SPEED_LSB = 13;
   localparam int CTL_ANEG_EN = 12;
   localparam int CTL_POWER_DOWN = 11;
   localparam int CTL_ISOLATE = 10;
   localparam int CTL_RESTART = 9;
   localparam int CTL_DUPLEX = 8;
   localparam int CTL_COL_TEST = 7;
   localparam int CTL_SPEED_MSB = 6;

   // Status register fields
   localparam int STA_T4 = 15;
   localparam int STA_X_FD = 14;
   localparam int STA_X_HD = 13;
   localparam int STA_10_FD = 12;
   localparam int STA_10_HD = 11;
   localparam int STA_T2_FD = 10;
   localparam int STA_T2_HD = 9;
   localparam int STA_EXT_STATUS = 8;
   localparam int STA_PREAMBLE_SUP = 6;
   localparam int STA_ANEG_DONE = 5;
   localparam int STA_REMOTE_FAULT = 4;
   localparam int STA_ANEG_ABILITY = 3;
   localparam int STA_LINK = 2;
   localparam int STA_EXT_CAP = 0;

   // Reset values
   localparam logic RST_DUPLEX = 1'b1;
   localparam logic [1:0] RST_SPEED = 2'h2;

   // Media modes
   localparam logic [1:0] MODE_100FX = 2'h0;
   localparam logic [1:0] MODE_1000X = 2'h1;
   localparam logic [1:0] MODE_SGMII_AUTO = 2'h2;
   localparam logic [1:0] MODE_SGMII_SW = 2'h3;

   // Speed encodings, MSB:LSB
   localparam logic [1:0] SPEED_1000 = 2'h2;
   localparam logic [1:0] SPEED_100 = 2'h1;

   // Management frame fields and strap capture counts
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [3:0] HDR_LAST = 4'hb;
   localparam logic [3:0] TA_LAST = 4'h1;
   localparam logic [3:0] DATA_LAST = 4'hf;
   localparam logic [1:0] INIT_LOAD = 2'h2;
   localparam logic [1:0] INIT_DONE = 2'h3;

   // Frame engine states, Gray from idle up to data
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_START = 3'h1,
      ST_HDR = 3'h3,
      ST_TA = 3'h2,
      ST_DATA = 3'h6
   } mgmt_state_t;

   // Live conditions from the fiber link logic
   typedef struct packed {
      logic link_up;
      logic aneg_done;
      logic aneg_bypass;
      logic remote_fault;
   } fiber_live_t;

endpackage

/* File: hw/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a group of pins
module pin_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // Pins and synchronised copy
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);

   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_q <= '0;
         q_out <= '0;
      end else begin
         meta_q <= d_in;
         q_out <= meta_q;
      end
   end

endmodule

`default_nettype wire

/* File: tb/fiber_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none

// Port-level checks on the fiber register block
module fiber_regs_chk (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // Watched ports
   input wire logic mdio_out,
   input wire logic mdio_oe_out,
   input wire logic [1:0] media_mode_in,
   input wire logic sw_reset_out,
   input wire logic aneg_restart_out,
   input wire logic aneg_enable_out,
   input wire logic power_down_out,
   input wire logic duplex_out
);
   logic [1:0] rs_hist_q;
   logic [1:0] sr_hist_q;

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);

   // Pulse history, so a cause may trail its pulse by two cycles
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rs_hist_q <= 2'h0;
         sr_hist_q <= 2'h0;
      end else begin
         rs_hist_q <= {rs_hist_q[0], aneg_restart_out};
         sr_hist_q <= {sr_hist_q[0], sw_reset_out};
      end
   end

   // Restart or soft reset within two cycles either side
   sequence restart_soon;
      ##[0:2] aneg_restart_out;
   endsequence
   sequence restart_near;
      (|rs_hist_q) or restart_soon;
   endsequence
   sequence swreset_near;
      (|sr_hist_q) or (##[0:2] sw_reset_out);
   endsequence

   restart_pulse_a: assert property (
      aneg_restart_out |=> !aneg_restart_out)
      else $error("restart pulse longer than one cycle");
   swrst_pulse_a: assert property (
      sw_reset_out |=> !sw_reset_out)
      else $error("soft reset pulse longer than one cycle");
   swrst_restart_a: assert property (
      sw_reset_out |-> restart_near)
      else $error("soft reset without negotiation restart");
   enable_restart_a: assert property (
      $changed(aneg_enable_out) && media_mode_in == $past(media_mode_in, 3)
      |-> restart_near)
      else $error("enable changed without restart");
   fx_enable_a: assert property (
      (media_mode_in == fiber_regs_pkg::MODE_100FX) [*2] |-> !aneg_enable_out)
      else $error("negotiation enabled in fx mode");
   duplex_apply_a: assert property (
      $changed(duplex_out) |-> restart_near)
      else $error("duplex applied without a restart cause");
   pd_exit_a: assert property (
      $fell(power_down_out) |-> swreset_near)
      else $error("power up without soft reset");
   ta_drive_a: assert property (
      $rose(mdio_oe_out) |-> (mdio_oe_out && !mdio_out) [*8])
      else $error("turnaround not driven low");
   bit_hold_a: assert property (
      $changed(mdio_out) && mdio_oe_out |=> $stable(mdio_out) [*8])
      else $error("read bit did not stand");
endmodule

bind fiber_ctrl_status_regs fiber_regs_chk fiber_regs_chk_inst (
   .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .mdio_out(mdio_out),
   .mdio_oe_out(mdio_oe_out), .media_mode_in(media_mode_in),
   .sw_reset_out(sw_reset_out), .aneg_restart_out(aneg_restart_out),
   .aneg_enable_out(aneg_enable_out), .power_down_out(power_down_out),
   .duplex_out(duplex_out));

`default_nettype wire

/* File: tb/mdio_host.sv */
`timescale 1ns/1ps
`default_nettype none

// Station manager sending management frames
module mdio_host (
   // Clock and data towards the device
   output logic mdc_out,
   output logic mdio_d_out,
   output logic mdio_oe_out,
   // Resolved wire level
   input wire logic mdio_in
);
   // Idle: clock low and still, data released
   initial begin
      mdc_out = 1'b0;
      mdio_d_out = 1'b1;
      mdio_oe_out = 1'b0;
   end

   // One frame; data changes after the falling edge
   task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
         input logic [4:0] ra, input logic [15:0] wd, input int pre,
         output logic [15:0] rd);
      logic [31:0] fr;
      fr = {2'b01, op, phy, ra, 2'b10, wd};
      rd = 16'h0000;
      for (int i = -pre; i < 32; i++) begin
         mdio_oe_out = (i < 14) || (op == fiber_regs_pkg::OP_WRITE);
         mdio_d_out = (i < 0) ? 1'b1 : fr[31 - i];
         #62.5;
         if (i >= 16) rd = {rd[14:0], mdio_in};
         mdc_out = 1'b1;
         #62.5;
         mdc_out = 1'b0;
      end
      mdio_oe_out = 1'b0;
      #62.5;
   endtask
endmodule

`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic ref_clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic strap = 1'b1;
   logic [4:0] phy_addr = 5'h05;
   logic [1:0] mode = 2'h1;
   logic [1:0] lspeed = 2'h2;
   fiber_regs_pkg::fiber_live_t live = '0;
   logic mdc, h_d, h_oe, d_out, d_oe, swr, rst_a, en, pd, dup;
   logic [1:0] spd;
   logic [15:0] rd;
   int miscompares = 0;
   int cmp_count = 0;
   int rcnt = 0;
   int scnt = 0;
   // Pull-up on the data line when nobody drives
   wire logic wire_lvl = d_oe ? d_out : (h_oe ? h_d : 1'b1);

   fiber_ctrl_status_regs fiber_ctrl_status_regs_inst (
      .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .mdc_in(mdc),
      .mdio_in(wire_lvl), .mdio_out(d_out), .mdio_oe_out(d_oe),
      .phy_addr_in(phy_addr), .negotiation_enable_strap_in(strap),
      .media_mode_in(mode), .line_speed_in(lspeed), .live_in(live),
      .sw_reset_out(swr), .aneg_restart_out(rst_a), .aneg_enable_out(en),
      .power_down_out(pd), .duplex_out(dup), .speed_out(spd));
   mdio_host mdio_host_inst (.mdc_out(mdc), .mdio_d_out(h_d),
      .mdio_oe_out(h_oe), .mdio_in(wire_lvl));

   always #4 ref_clk_in = ~ref_clk_in;

   // Pulse counters
   always @(posedge ref_clk_in) begin
      if (rst_a === 1'b1) rcnt++;
      if (swr === 1'b1) scnt++;
   end

   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s exp %h seen %h", what, exp, seen);
      end
   endtask

   task rd_reg(input logic [4:0] ra);
      mdio_host_inst.xfer(fiber_regs_pkg::OP_READ, phy_addr, ra, 16'h0, 0, rd);
      @(negedge ref_clk_in);
   endtask

   task wr_reg(input logic [15:0] wd);
      mdio_host_inst.xfer(fiber_regs_pkg::OP_WRITE, phy_addr,
         fiber_regs_pkg::REG_CONTROL, wd, 0, rd);
      @(negedge ref_clk_in);
   endtask

   task report_and_stop;
      if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Hardware reset with a given strap, then reset values
   task hw_reset(input logic s);
      int r0;
      @(negedge ref_clk_in);
      arst_n_in = 1'b0;
      strap = s;
      r0 = rcnt;
      repeat (3) @(negedge ref_clk_in);
      arst_n_in = 1'b1;
      repeat (8) @(negedge ref_clk_in);
      chk("hw restart", 16'(rcnt - r0), 16'h1);
      chk("duplex_out", dup, 16'h1);
      rd_reg(fiber_regs_pkg::REG_CONTROL);
      chk("ctrl rst", rd, {3'h0, s, 12'h140});
   endtask

   // Fixed bits per media mode, speed writable in mode 11
   task t_modes;
      logic [1:0] e;
      for (int i = 0; i < 5; i++) begin
         @(negedge ref_clk_in);
         mode = (i < 3) ? 2'(i) : 2'(i - 1);
         lspeed = (i == 3) ? fiber_regs_pkg::SPEED_100 : fiber_regs_pkg::SPEED_1000;
         e = (i == 0 || i == 3) ? 2'h1 : 2'h2;
         rd_reg(fiber_regs_pkg::REG_CONTROL);
         chk("speed", {rd[6], rd[13]}, e);
         chk("enable", en, (mode != 2'h0));
         rd_reg(fiber_regs_pkg::REG_STATUS);
         chk("status", rd, (mode == 2'h0) ? 16'h6141 : 16'h0149);
      end
      wr_reg(16'h3100);
      rd_reg(fiber_regs_pkg::REG_CONTROL);
      chk("speed rw", {rd[6], rd[13]}, 2'h1);
      chk("speed_out", spd, 2'h1);
      mode = 2'h1;
   endtask

   // Read-only bits, duplex apply points, enable change
   task t_ctrl;
      int r0;
      r0 = rcnt;
      wr_reg(16'h1480);
      chk("duplex held", dup, 16'h1);
      chk("no restart", 16'(rcnt - r0), 16'h0);
      rd_reg(fiber_regs_pkg::REG_CONTROL);
      chk("ctrl ro", rd, 16'h1040);
      wr_reg(16'h0000);
      chk("en restart", 16'(rcnt - r0), 16'h1);
      chk("duplex new", dup, 16'h0);
      chk("enable off", en, 16'h0);
      rd_reg(fiber_regs_pkg::REG_CONTROL);
      chk("self clear", rd, 16'h0040);
      wr_reg(16'h0300);
      chk("restart bit", 16'(rcnt - r0), 16'h2);
      chk("duplex rst", dup, 16'h1);
      wr_reg(16'h1100);
      chk("en back", 16'(rcnt - r0), 16'h3);
   endtask

   // Power down exit and soft reset
   task t_power;
      int r0;
      int s0;
      r0 = rcnt;
      s0 = scnt;
      wr_reg(16'h1900);
      chk("pd on", pd, 16'h1);
      wr_reg(16'h1000);
      chk("pd off", pd, 16'h0);
      chk("pd sreset", 16'(scnt - s0), 16'h1);
      chk("pd restart", 16'(rcnt - r0), 16'h1);
      chk("pd duplex", dup, 16'h0);
      wr_reg(16'h9100);
      chk("sreset", 16'(scnt - s0), 16'h2);
      chk("sr restart", 16'(rcnt - r0), 16'h2);
      chk("sr duplex", dup, 16'h1);
      rd_reg(fiber_regs_pkg::REG_CONTROL);
      chk("sr kept", rd, 16'h1140);
   endtask

   // Latched status bits and negotiation complete
   task t_status;
      @(negedge ref_clk_in);
      live = '{link_up: 1'b1, aneg_done: 1'b1, aneg_bypass: 1'b0,
         remote_fault: 1'b0};
      rd_reg(fiber_regs_pkg::REG_STATUS);
      rd_reg(fiber_regs_pkg::REG_STATUS);
      chk("status up", rd, 16'h016d);
      live.link_up = 1'b0;
      live.remote_fault = 1'b1;
      @(negedge ref_clk_in);
      live.link_up = 1'b1;
      live.remote_fault = 1'b0;
      rd_reg(fiber_regs_pkg::REG_STATUS);
      chk("link low", rd[2], 16'h0);
      chk("fault high", rd[4], 16'h1);
      rd_reg(fiber_regs_pkg::REG_STATUS);
      chk("link live", rd[2], 16'h1);
      chk("fault live", rd[4], 16'h0);
      mode = 2'h0;
      rd_reg(fiber_regs_pkg::REG_STATUS);
      chk("aneg off", rd[5], 16'h0);
      live.aneg_bypass = 1'b1;
      live.remote_fault = 1'b1;
      mode = 2'h2;
      @(negedge ref_clk_in);
      live.remote_fault = 1'b0;
      rd_reg(fiber_regs_pkg::REG_STATUS);
      chk("bypass", rd[5], 16'h0);
      chk("sgmii fault", rd[4], 16'h0);
      mode = 2'h1;
      live.aneg_bypass = 1'b0;
   endtask

   // Foreign address, unmapped register, preamble frames
   task t_refuse;
      mdio_host_inst.xfer(fiber_regs_pkg::OP_WRITE, phy_addr ^ 5'h01,
         fiber_regs_pkg::REG_CONTROL, 16'h0000, 0, rd);
      mdio_host_inst.xfer(fiber_regs_pkg::OP_READ, phy_addr ^ 5'h01,
         fiber_regs_pkg::REG_STATUS, 16'h0, 0, rd);
      chk("foreign rd", rd, 16'hffff);
      mdio_host_inst.xfer(fiber_regs_pkg::OP_READ, phy_addr, 5'h05, 16'h0,
         32, rd);
      chk("unmapped", rd, 16'h0000);
      mdio_host_inst.xfer(fiber_regs_pkg::OP_READ, phy_addr,
         fiber_regs_pkg::REG_CONTROL, 16'h0, 32, rd);
      chk("preamble rd", rd, 16'h1140);
   endtask

   initial begin
      hw_reset(1'b1);
      t_modes;
      t_ctrl;
      t_power;
      t_status;
      t_refuse;
      hw_reset(1'b0);
      report_and_stop;
   end

   // Watchdog well past the expected run
   initial begin
      #400000;
      miscompares++;
      report_and_stop;
   end
endmodule

`default_nettype wire
